/* rtl/nlb_nt_loop2.sv */
// network-side termination activation machine with loopback handling
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module nlb_nt_loop2
    import nlb_pkg::*;
#(
    parameter int unsigned BD_W   = 18,
    parameter int unsigned MS_CYC = NLB_MS_CYC
) (
    // clock and reset
    input  wire logic            core_clk_in,
    input  wire logic            arst_n_in,
    // register port
    input  wire logic [3:0]      reg_addr_in,
    input  wire logic [31:0]     reg_wdata_in,
    input  wire logic            reg_wr_in,
    input  wire logic            reg_rd_in,
    output logic [31:0]          reg_rdata_out,
    // line side events
    input  wire logic            wake_tone_in,
    input  wire logic            line_sync_in,
    input  wire logic            los_line_in,
    input  wire logic            act_rx_in,
    input  wire logic            dea_rx_in,
    input  wire logic            eoc_loop2_in,
    input  wire logic            eoc_rtn_in,
    // T interface events
    input  wire logic            te_info3_in,
    input  wire logic            t_sync_in,
    // channel data, one word per frame strobe
    input  wire logic            frame_stb_in,
    input  wire logic [BD_W-1:0] bd_line_rx_in,
    input  wire logic [BD_W-1:0] bd_te_rx_in,
    output logic [BD_W-1:0]      bd_line_tx_out,
    output logic [BD_W-1:0]      bd_te_tx_out,
    // overhead and signal selection
    output logic                 act_tx_out,
    output nlb_info_t            info_te_out,
    output logic                 echo_zero_out,
    output logic                 te_rx_block_out,
    output logic                 loop_active_out,
    output logic                 startup_over_out
);
    localparam logic [BD_W-1:0] ONES = '1;

    logic       rst_meta;
    logic       rst_n;
    nlb_tmr_if  tmr ();

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    nlb_budget_timer #(
        .MS_CYC (MS_CYC)
    ) u_timer (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_n),
        .tmr      (tmr)
    );

    // ---------------- control state machine ----------------
    nlb_state_t state;
    nlb_state_t next_state;
    logic [1:0] ctrl;
    logic       loop_cmd;
    logic       in_term;
    logic       in_loop;

    assign in_term = (state == NLB_TERM_SYNCED) ||
                     (state == NLB_TERM_LOCAL_READY) ||
                     (state == NLB_TERM_TRANSPARENT);
    assign in_loop = (state == NLB_LOOP_SYNCED) ||
                     (state == NLB_LOOP_LOCAL_READY) ||
                     (state == NLB_LOOP_TRANSPARENT);
    assign loop_cmd = eoc_loop2_in && ctrl[NLB_CTRL_LOOPEN];

    always_comb begin
        next_state = state;
        if (los_line_in) begin
            next_state = NLB_RESET; // see R15
        end else if (in_term && loop_cmd) begin
            next_state = NLB_LOOP_SYNCED; // see R1
        end else if (in_loop && eoc_rtn_in) begin
            next_state = NLB_TERM_SYNCED; // see R16
        end else begin
            case (state)
                NLB_RESET: begin
                    if (line_sync_in) begin
                        next_state = NLB_TERM_SYNCED;
                    end
                end
                NLB_TERM_SYNCED: begin
                    if (!dea_rx_in) begin
                        next_state = NLB_TERM_DEACT_PENDING; // see R14
                    end else if (te_info3_in) begin
                        next_state = NLB_TERM_LOCAL_READY; // see R16
                    end
                end
                NLB_TERM_LOCAL_READY: begin
                    if (!dea_rx_in) begin
                        next_state = NLB_TERM_DEACT_PENDING;
                    end else if (act_rx_in) begin
                        next_state = NLB_TERM_TRANSPARENT; // see R16
                    end
                end
                NLB_TERM_TRANSPARENT: begin
                    if (!dea_rx_in) begin
                        next_state = NLB_TERM_DEACT_PENDING;
                    end
                end
                NLB_TERM_DEACT_PENDING: begin
                    // only loss of signal leaves; ACT=1 is never acted on
                    next_state = NLB_TERM_DEACT_PENDING; // see R15
                end
                NLB_LOOP_SYNCED: begin
                    if (t_sync_in) begin
                        next_state = NLB_LOOP_LOCAL_READY; // see R5
                    end
                end
                NLB_LOOP_LOCAL_READY: begin
                    if (!t_sync_in) begin
                        next_state = NLB_LOOP_SYNCED; // see R8
                    end else if (act_rx_in) begin
                        next_state = NLB_LOOP_TRANSPARENT; // see R6
                    end
                end
                NLB_LOOP_TRANSPARENT: begin
                    if (!t_sync_in) begin
                        next_state = NLB_LOOP_SYNCED; // see R8
                    end
                end
                default: begin
                    next_state = NLB_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= NLB_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ---------------- overhead bits and signal selection ----------------
    logic      next_act;
    nlb_info_t next_info;
    logic      next_echo0;
    logic      next_block;
    logic      next_loop;

    always_comb begin
        next_act   = 1'b0;
        next_info  = NLB_INFO0;
        next_echo0 = 1'b0;
        next_block = 1'b0;
        next_loop  = 1'b0;
        case (next_state)
            NLB_RESET: begin
                next_info = NLB_INFO0;
            end
            NLB_TERM_SYNCED: begin
                next_info = NLB_INFO2;
            end
            NLB_TERM_LOCAL_READY: begin
                next_info = NLB_INFO2;
                next_act  = 1'b1;
            end
            NLB_TERM_TRANSPARENT: begin
                next_info = NLB_INFO4;
                next_act  = 1'b1;
            end
            NLB_TERM_DEACT_PENDING: begin
                // outputs stay as they were in the state before
                next_info = info_te_out;
                next_act  = act_tx_out;
            end
            NLB_LOOP_SYNCED: begin
                next_info  = NLB_INFO2; // see R3, see R8
                next_act   = 1'b0;      // see R2
                next_block = 1'b1;      // see R4
                next_loop  = 1'b1;
            end
            NLB_LOOP_LOCAL_READY: begin
                next_info  = NLB_INFO2;
                next_act   = 1'b1;      // see R5
                next_block = 1'b1;      // see R4
                next_loop  = 1'b1;
            end
            NLB_LOOP_TRANSPARENT: begin
                next_info  = NLB_INFO4; // see R6
                next_act   = 1'b1;
                next_echo0 = 1'b1;      // see R6
                next_block = 1'b1;      // see R4
                next_loop  = 1'b1;
            end
            default: begin
                next_info = NLB_INFO0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            act_tx_out      <= 1'b0;
            info_te_out     <= NLB_INFO0;
            echo_zero_out   <= 1'b0;
            te_rx_block_out <= 1'b0;
            loop_active_out <= 1'b0;
        end else begin
            act_tx_out      <= next_act;
            info_te_out     <= next_info;
            echo_zero_out   <= next_echo0;
            te_rx_block_out <= next_block;
            loop_active_out <= next_loop;
        end
    end

    // ---------------- channel data path ----------------
    logic [BD_W-1:0] next_bd_line;
    logic [BD_W-1:0] next_bd_te;
    logic            lp_rdy;

    assign lp_rdy = (next_state == NLB_LOOP_LOCAL_READY) ||
                    (next_state == NLB_LOOP_TRANSPARENT);

    always_comb begin
        next_bd_line = bd_line_tx_out;
        next_bd_te   = bd_te_tx_out;
        if (!lp_rdy && next_state != NLB_TERM_TRANSPARENT) begin
            next_bd_line = ONES; // see R8
        end
        if (next_state != NLB_TERM_TRANSPARENT &&
            next_state != NLB_LOOP_TRANSPARENT) begin
            next_bd_te = ONES;
        end
        if (frame_stb_in) begin
            case (next_state)
                NLB_TERM_TRANSPARENT: begin
                    next_bd_line = bd_te_rx_in;
                    next_bd_te   = bd_line_rx_in;
                end
                NLB_LOOP_LOCAL_READY: begin
                    next_bd_line = bd_te_tx_out; // see R7
                end
                NLB_LOOP_TRANSPARENT: begin
                    next_bd_line = bd_te_tx_out; // see R7
                    next_bd_te   = bd_line_rx_in; // see R6
                end
                default: begin
                    next_bd_line = next_bd_line;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bd_line_tx_out <= ONES;
            bd_te_tx_out   <= ONES;
        end else begin
            bd_line_tx_out <= next_bd_line;
            bd_te_tx_out   <= next_bd_te;
        end
    end

    // ---------------- start-up budget and registers ----------------
    logic        over;
    logic        next_over;
    logic [1:0]  next_ctrl;
    logic [31:0] next_rdata;
    logic [31:0] status;

    // timing runs from wake tone until this end reaches frame sync
    assign tmr.start = wake_tone_in && (state == NLB_RESET); // see R20
    assign tmr.stop  = (state == NLB_RESET) &&
                       (next_state == NLB_TERM_SYNCED);      // see R20
    assign tmr.limit = ctrl[NLB_CTRL_WARM] ? NLB_WARM_DEV_MS  // see R19
                                           : NLB_COLD_DEV_MS; // see R18

    assign status = {24'h00_0000, tmr.run, over, act_tx_out,
                     info_te_out, state};

    always_comb begin
        next_ctrl = ctrl;
        next_over = over;
        if (reg_wr_in && reg_addr_in == NLB_ADDR_CTRL) begin
            next_ctrl = reg_wdata_in[1:0];
        end
        if (reg_wr_in && reg_addr_in == NLB_ADDR_STATUS &&
            reg_wdata_in[NLB_ST_OVER]) begin
            next_over = 1'b0;
        end
        // a new overrun in the clearing cycle still sticks
        if (tmr.over && tmr.run) begin
            next_over = 1'b1; // see R18, see R19
        end
        next_rdata = 32'h0000_0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                NLB_ADDR_CTRL:   next_rdata = {30'h0000_0000, ctrl};
                NLB_ADDR_STATUS: next_rdata = status;
                NLB_ADDR_TIME:   next_rdata = {16'h0000, tmr.elapsed};
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl             <= NLB_CTRL_RESET;
            over             <= 1'b0;
            reg_rdata_out    <= 32'h0000_0000;
            startup_over_out <= 1'b0;
        end else begin
            ctrl             <= next_ctrl;
            over             <= next_over;
            reg_rdata_out    <= next_rdata;
            startup_over_out <= next_over;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    logic calm;
    assign calm = !los_line_in && !eoc_rtn_in;

    chk_loop_entry: assert property ( // see R1
        (in_term && loop_cmd && !los_line_in) |=>
        state == NLB_LOOP_SYNCED)
        else $error("loop command did not reach loop_synced");
    chk_act_drop: assert property ( // see R2
        ((state == NLB_TERM_LOCAL_READY || state == NLB_TERM_TRANSPARENT)
         && loop_cmd && !los_line_in) |=> !act_tx_out)
        else $error("ACT not dropped on loop entry");
    chk_info_revert: assert property ( // see R3
        (state == NLB_TERM_TRANSPARENT && loop_cmd && !los_line_in) |=>
        info_te_out == NLB_INFO2)
        else $error("INFO 2 not restored on loop entry");
    chk_te_block: assert property ( // see R4
        in_loop |-> te_rx_block_out && loop_active_out)
        else $error("terminal signals not blocked in loop");
    chk_self_sync: assert property ( // see R5
        (state == NLB_LOOP_SYNCED && t_sync_in && calm) |=>
        state == NLB_LOOP_LOCAL_READY && act_tx_out)
        else $error("self sync did not raise ACT");
    chk_loop_transp: assert property ( // see R6
        (state == NLB_LOOP_LOCAL_READY && t_sync_in && act_rx_in && calm)
        |=> state == NLB_LOOP_TRANSPARENT && info_te_out == NLB_INFO4 &&
        echo_zero_out)
        else $error("loop_transparent not entered");
    chk_loop_data: assert property ( // see R7
        (state == NLB_LOOP_TRANSPARENT && t_sync_in && calm &&
         frame_stb_in) |=> bd_line_tx_out == $past(bd_te_tx_out))
        else $error("looped data not sent to line");
    chk_t_loss: assert property ( // see R8
        (state == NLB_LOOP_TRANSPARENT && !t_sync_in && calm) |=>
        state == NLB_LOOP_SYNCED && !act_tx_out &&
        info_te_out == NLB_INFO2 && bd_line_tx_out == ONES)
        else $error("T loss did not stop the loop");
    chk_dea_pend: assert property ( // see R14
        (state == NLB_TERM_SYNCED && !dea_rx_in && calm && !loop_cmd) |=>
        state == NLB_TERM_DEACT_PENDING)
        else $error("DEA=0 not honoured");
    chk_pend_hold: assert property ( // see R15
        (state == NLB_TERM_DEACT_PENDING && !los_line_in) |=>
        state == NLB_TERM_DEACT_PENDING ##1 1'b1)
        else $error("deact pending left without loss of signal");
    chk_sl0_deact: assert property ( // see R15
        (state != NLB_RESET && los_line_in) |=> state == NLB_RESET &&
        info_te_out == NLB_INFO0)
        else $error("loss of signal did not deactivate");
    chk_normal_act: assert property ( // see R16
        (state == NLB_TERM_LOCAL_READY && act_rx_in && dea_rx_in &&
         calm && !loop_cmd) |=> state == NLB_TERM_TRANSPARENT)
        else $error("ACT=1 did not give term_transparent");

    cov_loop_up: cover property (
        state == NLB_LOOP_SYNCED ##[1:100] state == NLB_LOOP_TRANSPARENT);
    cov_rtn: cover property (
        state == NLB_LOOP_TRANSPARENT ##1 state == NLB_TERM_SYNCED);
    cov_deact: cover property (
        state == NLB_TERM_DEACT_PENDING ##[1:100] state == NLB_RESET);
    cov_over: cover property ($rose(over));
endmodule
`default_nettype wire

/* rtl/nlb_pkg.sv */
// constants, states and register map of the loopback activation block
//
// What this block does, and in R9 to R13 what the line end does
// R1: loopback command in term states moves device to loop_synced.
// R2: entering loop_synced from local_ready or transparent sends ACT=0.
// R3: loopback command in term_transparent reverts output to INFO 2.
// R4: in all loop states, terminal equipment signals are blocked.
// R5: in loop_synced, T self-sync means INFO 3; go loop_local_ready, ACT=1.
// R6: ACT=1 from line in loop_local_ready gives loop_transparent, INFO 4.
// R7: in loop_local_ready and loop_transparent, line data is own T data.
// R8: T loss in loop ready/transparent returns to loop_synced, ones.
// R9: line end holds ACT=0 until loopback command is confirmed.
// R10: line end may loop without resetting the transceivers.
// R11: line end sends channel requests only after frame sync.
// R12: on loopback release the line end returns to line_synced.
// R13: line end sends DEA=0 three superframes, then SL0.
// R14: DEA=0 received in term_synced enters term_deact_pending.
// R15: deact pending never reaches transparent; SL0 loss deactivates.
// R16: normal return: INFO 3 gives local_ready, ACT=1 gives transparent.
// R17: start-up within 300 ms warm, 600 ms with regenerator, 15 s cold.
// R18: cold start split: device 5 s, line end 10 s.
// R19: warm start split: device 150 ms, line end 150 ms.
// R20: start-up measured from wake-up tone to line frame sync.
package nlb_pkg;
    typedef enum logic [2:0] {
        NLB_RESET, NLB_TERM_SYNCED, NLB_TERM_LOCAL_READY,
        NLB_TERM_TRANSPARENT, NLB_TERM_DEACT_PENDING,
        NLB_LOOP_SYNCED, NLB_LOOP_LOCAL_READY, NLB_LOOP_TRANSPARENT
    } nlb_state_t;
    typedef enum logic [1:0] {NLB_INFO0, NLB_INFO2, NLB_INFO4} nlb_info_t;
    localparam int unsigned NLB_CLK_NS       = 5;
    localparam int unsigned NLB_MS_NS        = 1000000;
    localparam int unsigned NLB_MS_CYC       = NLB_MS_NS / NLB_CLK_NS;
    localparam int unsigned NLB_WARM_SYS_MS  = 300;   // see R17
    localparam int unsigned NLB_WARM_REG_MS  = 600;   // see R17
    localparam int unsigned NLB_COLD_SYS_MS  = 15000; // see R17
    localparam logic [15:0] NLB_WARM_DEV_MS  = 16'h0096;
    localparam logic [15:0] NLB_COLD_DEV_MS  = 16'h1388;
    localparam logic [15:0] NLB_COLD_LINE_MS = 16'h2710;
    localparam logic [3:0]  NLB_ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  NLB_ADDR_STATUS  = 4'h4;
    localparam logic [3:0]  NLB_ADDR_TIME    = 4'h8;
    localparam int unsigned NLB_CTRL_WARM    = 0;
    localparam int unsigned NLB_CTRL_LOOPEN  = 1;
    localparam logic [1:0]  NLB_CTRL_RESET   = 2'h2;
    localparam int unsigned NLB_ST_ACT       = 5;
    localparam int unsigned NLB_ST_OVER      = 6;
    localparam int unsigned NLB_ST_RUN       = 7;
endpackage

/* rtl/nlb_tmr_if.sv */
// link between the state machine and its start-up budget timer
`timescale 1ns/10ps
`default_nettype none
interface nlb_tmr_if;
    logic        start;
    logic        stop;
    logic [15:0] limit;
    logic        run;
    logic        over;
    logic [15:0] elapsed;
    modport owner (output start, stop, limit, input run, over, elapsed);
    modport timer (input start, stop, limit, output run, over, elapsed);
endinterface
`default_nettype wire

/* rtl/nlb_budget_timer.sv */
// millisecond start-up timer checked against a budget
`timescale 1ns/10ps
`default_nettype none
module nlb_budget_timer
    import nlb_pkg::*;
#(
    parameter int unsigned MS_CYC = NLB_MS_CYC
) (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    nlb_tmr_if.timer   tmr
);
    logic [31:0] pre;
    logic [31:0] next_pre;
    logic        run;
    logic        next_run;
    logic [15:0] ms;
    logic [15:0] next_ms;

    always_comb begin
        next_pre = pre;
        next_run = run;
        next_ms  = ms;
        if (tmr.start) begin
            next_pre = 32'h0000_0000;
            next_ms  = 16'h0000;
            next_run = 1'b1;
        end else if (tmr.stop) begin
            next_run = 1'b0;
        end else if (run) begin
            if (pre == 32'(MS_CYC - 1)) begin
                next_pre = 32'h0000_0000;
                if (ms != 16'hffff) begin
                    next_ms = ms + 16'h0001;
                end
            end else begin
                next_pre = pre + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre <= 32'h0000_0000;
            run <= 1'b0;
            ms  <= 16'h0000;
        end else begin
            pre <= next_pre;
            run <= next_run;
            ms  <= next_ms;
        end
    end

    // device share of the budget is "at most", so only beyond it is late
    assign tmr.run     = run;
    assign tmr.elapsed = ms;
    assign tmr.over    = (ms > tmr.limit); // see R18, see R19
endmodule
`default_nettype wire

/* testbench/nlb_lt_model.sv */
// line termination model driving overhead bits and maintenance commands
`timescale 1ns/10ps
`default_nettype none
module nlb_lt_model #(
    parameter int CONF_CYC = 60,
    parameter int SF_CYC   = 80
) (
    // clock, reset and device status
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic dev_sync_in,
    input  wire logic act_dev_in,
    // requests from the bench
    input  wire logic go_loop_in,
    input  wire logic go_rtn_in,
    input  wire logic go_deact_in,
    // line signals toward the device
    output logic      act_out,
    output logic      dea_out,
    output logic      loop2_out,
    output logic      rtn_out,
    output logic      los_out
);
    int   cnt;
    logic act_ok;
    logic deact;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {act_out, loop2_out, rtn_out, los_out, deact} <= 5'h00;
            {dea_out, act_ok} <= 2'h3;
            cnt <= 0;
        end else begin
            loop2_out <= 1'h0;
            rtn_out <= 1'h0;
            cnt <= (cnt > 0) ? cnt - 1 : 0;
            // no reset first; command only once framed, ACT low till confirmed
            if (go_loop_in && dev_sync_in) begin
                act_ok <= 1'h0;
                loop2_out <= 1'h1;
                cnt <= CONF_CYC;
            end else if (cnt == 1 && !deact)
                act_ok <= 1'h1;
            if (go_rtn_in)
                rtn_out <= 1'h1;
            // deactivation: DEA low for a while, ACT ignored, then silence
            if (go_deact_in) begin
                deact <= 1'h1;
                act_ok <= 1'h0;
                dea_out <= 1'h0;
                cnt <= SF_CYC;
            end else if (cnt == 1 && deact)
                los_out <= 1'h1;
            act_out <= act_ok & act_dev_in;
        end
    end
endmodule
`default_nettype wire

/* testbench/nlb_nt_loop2_bench.sv */
// self-checking bench for the loopback activation block
`timescale 1ns/10ps
`default_nettype none
module nlb_nt_loop2_bench;
    import nlb_pkg::*;
    localparam int unsigned BD_W = 18;
    localparam logic [17:0] ONES = 18'h3_ffff;
    logic            core_clk_in = 1'h0;
    logic            arst_n_in = 1'h0;
    logic [3:0]      reg_addr_in = 4'h0;
    logic [31:0]     reg_wdata_in = 32'h0000_0000;
    logic            reg_wr_in = 1'h0;
    logic            reg_rd_in = 1'h0;
    logic            te_info3_in = 1'h0;
    logic            line_sync_in = 1'h0;
    logic            t_sync_in = 1'h0;
    logic            frame_stb_in = 1'h0;
    logic [3:0]      pv = 4'h0;
    logic [BD_W-1:0] bd_line_rx_in = 18'h0_0000;
    logic [BD_W-1:0] bd_te_rx_in = 18'h0_0000;
    logic [BD_W-1:0] bd_line_tx_out, bd_te_tx_out;
    logic [31:0]     reg_rdata_out, rd_val;
    logic            los_line_in, act_rx_in, dea_rx_in, eoc_loop2_in;
    logic            eoc_rtn_in, act_tx_out, echo_zero_out, te_rx_block_out;
    logic            loop_active_out, startup_over_out;
    nlb_info_t       info_te_out;
    int              num_errors = 0;
    int              compares = 0;

    always #2.5 core_clk_in = ~core_clk_in;

    nlb_nt_loop2 #(.BD_W(BD_W), .MS_CYC(4)) dut (
        .core_clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .wake_tone_in(pv[0]), .line_sync_in,
        .los_line_in, .act_rx_in, .dea_rx_in, .eoc_loop2_in, .eoc_rtn_in,
        .te_info3_in, .t_sync_in, .frame_stb_in, .bd_line_rx_in,
        .bd_te_rx_in, .bd_line_tx_out, .bd_te_tx_out, .act_tx_out,
        .info_te_out, .echo_zero_out, .te_rx_block_out, .loop_active_out,
        .startup_over_out);
    nlb_lt_model lt (.clk_in(core_clk_in), .rst_n_in(arst_n_in),
        .dev_sync_in(line_sync_in), .act_dev_in(act_tx_out),
        .go_loop_in(pv[1]), .go_rtn_in(pv[2]), .go_deact_in(pv[3]),
        .act_out(act_rx_in), .dea_out(dea_rx_in), .loop2_out(eoc_loop2_in),
        .rtn_out(eoc_rtn_in), .los_out(los_line_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'h1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'h0;
        #1 rd_val = reg_rdata_out;
    endtask
    // bit 0 wake tone, 1 loop command, 2 return, 3 deactivate
    task automatic pulse(input logic [3:0] m);
        @(posedge core_clk_in);
        pv <= m;
        @(posedge core_clk_in);
        pv <= 4'h0;
    endtask
    task automatic wait_st(input logic [2:0] s);
        int n;
        n = 0;
        rd(NLB_ADDR_STATUS);
        while (rd_val[2:0] !== s && n < 60) begin
            rd(NLB_ADDR_STATUS);
            n++;
        end
        chk(rd_val[2:0], s);
    endtask
    // act, echo zero, block, loop active, info
    task automatic chk_out(input logic [5:0] e);
        chk({act_tx_out, echo_zero_out, te_rx_block_out, loop_active_out,
             info_te_out}, e);
    endtask
    task automatic wrap_up();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #50000;
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge core_clk_in);
        arst_n_in <= 1'h1;
        repeat (3) @(posedge core_clk_in);
        rd(NLB_ADDR_CTRL);
        chk(rd_val, 32'h0000_0002);
        rd(4'hc);
        chk(rd_val, 32'h0000_0000);
        wr(NLB_ADDR_CTRL, 32'h0000_0003);
        pulse(4'h1);
        repeat (560) @(posedge core_clk_in);
        rd(NLB_ADDR_STATUS);
        chk(rd_val[7:6], 2'h2);
        repeat (80) @(posedge core_clk_in);
        line_sync_in <= 1'h1;
        wait_st(3'h1);
        chk(rd_val[7:6], 2'h1);
        chk(startup_over_out, 1'h1);
        rd(NLB_ADDR_TIME);
        chk(rd_val[15:0] > NLB_WARM_DEV_MS, 1'h1);
        wr(NLB_ADDR_STATUS, 32'h0000_0040);
        rd(NLB_ADDR_STATUS);
        chk(rd_val[6], 1'h0);
        @(posedge core_clk_in);
        te_info3_in <= 1'h1;
        wait_st(3'h3);
        chk_out(6'h22);
        pulse(4'h2);
        wait_st(3'h5);
        chk_out(6'h0d);
        chk(bd_line_tx_out, ONES);
        @(posedge core_clk_in);
        t_sync_in <= 1'h1;
        wait_st(3'h6);
        chk_out(6'h2d);
        wait_st(3'h7);
        chk_out(6'h3e);
        @(posedge core_clk_in);
        bd_line_rx_in <= 18'h2_a5c3;
        bd_te_rx_in <= 18'h1_3c96;
        frame_stb_in <= 1'h1;
        @(posedge core_clk_in);
        bd_line_rx_in <= 18'h0_5a3c;
        @(posedge core_clk_in);
        frame_stb_in <= 1'h0;
        @(posedge core_clk_in);
        #1 chk(bd_line_tx_out, 18'h2_a5c3);
        chk(bd_te_tx_out, 18'h0_5a3c);
        @(posedge core_clk_in);
        t_sync_in <= 1'h0;
        wait_st(3'h5);
        chk_out(6'h0d);
        chk(bd_line_tx_out & bd_te_tx_out, ONES);
        pulse(4'h4);
        wait_st(3'h3);
        @(posedge core_clk_in);
        te_info3_in <= 1'h0;
        pulse(4'h2);
        wait_st(3'h5);
        pulse(4'h4);
        wait_st(3'h1);
        pulse(4'h8);
        wait_st(3'h4);
        @(posedge core_clk_in);
        te_info3_in <= 1'h1;
        repeat (20) @(posedge core_clk_in);
        rd(NLB_ADDR_STATUS);
        chk(rd_val[2:0], 3'h4);
        wait_st(3'h0);
        wr(NLB_ADDR_CTRL, 32'h0000_0002);
        pulse(4'h1);
        repeat (700) @(posedge core_clk_in);
        rd(NLB_ADDR_STATUS);
        chk(rd_val[7:6], 2'h2);
        wrap_up();
    end
endmodule
`default_nettype wire
